/* File: verilog/halfband_pkg.sv */
// Constants, coefficients, mode types and decoders for the half-band filter
package halfband_pkg;

    localparam int IN_W       = 12;
    localparam int OUT_W      = 16;
    localparam int ACC_W      = 36;
    localparam int COEF_W     = 16;
    localparam int COEF_FRAC  = 15;
    localparam int HB_TAPS    = 39;
    localparam int HB_MID     = 19;
    localparam int HB_SIDE    = 10;
    localparam int HB_LINE    = 2 * HB_TAPS - 1;
    localparam int OUT_SHIFT  = COEF_FRAC + IN_W - OUT_W;
    localparam int XS_SHIFT   = 4;

    // Group delay figures in clock cycles
    localparam int LAT_FIRST  = 15;
    localparam int LAT_PEAK   = 34;
    localparam int LAT_LAST   = 53;
    localparam int FIXED_STG  = 6;
    localparam int PAD_STG    = LAT_FIRST - FIXED_STG;
    localparam int DBL_STG    = LAT_PEAK;

    // Sixteen bits wraps to zero in four bits
    localparam logic [3:0] FULL_BITS = 4'(OUT_W);
    localparam logic [3:0] EXT_BITS  = 4'hc;

    // Plain default coefficients, odd offsets from the centre
    localparam logic signed [COEF_W-1:0] HB_CENTER = 16'sh4000;
    localparam logic signed [COEF_W-1:0] HB_COEF [HB_SIDE] = '{
        16'sh288c, -16'sh0d84, 16'sh081c, -16'sh05cb, 16'sh0481,
        -16'sh03af, 16'sh031e, -16'sh02b4, 16'sh0262, -16'sh0222
    };

    // AXI4-Lite map
    localparam int AXI_ADDR_W = 4;
    localparam logic [AXI_ADDR_W-1:0] CTRL_OFF   = 4'h0;
    localparam logic [AXI_ADDR_W-1:0] STATUS_OFF = 4'h4;
    localparam int CTRL_SYNC_BIT = 0;
    localparam int CTRL_CLR_BIT  = 1;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic interp;
        logic gain0;
        logic lim15;
        logic decim;
        logic two_chan;
        logic dbl;
        logic bypass;
        logic xsinx;
    } mode_t;

    // Effective output bits from the rounding select
    function automatic logic [3:0] out_bits(input logic [2:0] rnd);
        out_bits = (rnd == 3'h7) ? FULL_BITS : 4'h8 + {1'h0, rnd};
    endfunction

    function automatic mode_t decode_mode(input logic int_n, input logic dec,
                                          input logic ext_en, input logic [1:0] ext);
        mode_t m;
        m = '0;
        m.interp = ~int_n;
        m.gain0  = ~int_n & ~dec;
        m.lim15  = ~int_n & dec;
        m.decim  = int_n & ~dec;
        if (ext_en)
        begin
            case (ext)
                2'h1: m.xsinx = 1'h1;
                2'h2:
                begin
                    m.dbl    = ~(int_n & dec);
                    m.bypass = int_n & dec;
                    m.xsinx  = ~int_n & dec;
                    m.gain0  = ~int_n;
                    m.lim15  = 1'h0;
                end
                2'h3:
                begin
                    m.two_chan = ~(int_n & dec);
                    m.bypass   = int_n & dec;
                    m.xsinx    = dec;
                    m.gain0    = ~int_n;
                    m.lim15    = 1'h0;
                end
                default: m.xsinx = 1'h0;
            endcase
        end
        decode_mode = m;
    endfunction

endpackage

/* File: verilog/sample_if.sv */
// Carrier between the top-level datapath and the FIR core
`timescale 1ns/100ps
interface sample_if;
    logic signed [halfband_pkg::IN_W-1:0]  x;
    logic                                  two_chan;
    logic                                  bypass;
    logic signed [halfband_pkg::ACC_W-1:0] acc;

    modport core (input x, input two_chan, input bypass, output acc);
    modport feed (output x, output two_chan, output bypass, input acc);
endinterface

/* File: verilog/halfband_core.sv */
// Symmetric 39-tap half-band FIR core with two-channel tap stride
`timescale 1ns/100ps
module halfband_core (
    input wire logic sys_clk,
    input wire logic rst_n,
    sample_if.core   sif
);

    localparam int ACC_W = halfband_pkg::ACC_W;

    logic signed [halfband_pkg::IN_W-1:0]  dl_q [halfband_pkg::HB_LINE];
    logic signed [halfband_pkg::ACC_W-1:0] acc_d;
    logic signed [halfband_pkg::ACC_W-1:0] acc_q;

    function automatic logic signed [halfband_pkg::IN_W:0] tap(input int k);
        tap = (halfband_pkg::IN_W+1)'(sif.two_chan ? dl_q[2*k] : dl_q[k]);
    endfunction

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < halfband_pkg::HB_LINE; i++)
                dl_q[i] <= '0;
        end
        else
        begin
            dl_q[0] <= sif.x;
            for (int i = 1; i < halfband_pkg::HB_LINE; i++)
                dl_q[i] <= dl_q[i-1];
        end
    end

    always_comb
    begin
        int o;
        o = 0;
        acc_d = ACC_W'(tap(halfband_pkg::HB_MID)) * halfband_pkg::HB_CENTER;
        for (int k = 0; k < halfband_pkg::HB_SIDE; k++)
        begin
            o = 2 * k + 1;
            acc_d = acc_d + ACC_W'(tap(halfband_pkg::HB_MID - o) + tap(halfband_pkg::HB_MID + o))
                          * halfband_pkg::HB_COEF[k];
        end
        if (sif.bypass)
            acc_d = ACC_W'(tap(halfband_pkg::HB_MID)) <<< halfband_pkg::COEF_FRAC;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            acc_q <= '0;
        else
            acc_q <= acc_d;
    end

    assign sif.acc = acc_q;

endmodule // halfband_core

/* File: verilog/halfband_interp_decim_filter.sv */
// Half-band interpolating and decimating filter top with AXI4-Lite status
`timescale 1ns/100ps
module halfband_interp_decim_filter (
    input  wire logic                                 sys_clk,
    input  wire logic                                 rst_n,
    input  wire logic [halfband_pkg::IN_W-1:0]        sample_in,
    input  wire logic                                 sync,
    input  wire logic                                 interp_select_n,
    input  wire logic                                 decim_select,
    input  wire logic [2:0]                           round_position,
    input  wire logic                                 output_format_select,
    input  wire logic                                 out_enable_n,
    output logic [11:0]                               result_upper_bits,
    output logic                                      result_upper_oe,
    input  wire logic [3:0]                           result_low_dual_bits_in,
    output logic [3:0]                                result_low_dual_bits_out,
    output logic [3:0]                                result_low_dual_bits_oe,
    input  wire logic [halfband_pkg::AXI_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                                 s_axi_awvalid,
    output logic                                      s_axi_awready,
    input  wire logic [31:0]                          s_axi_wdata,
    input  wire logic [3:0]                           s_axi_wstrb,
    input  wire logic                                 s_axi_wvalid,
    output logic                                      s_axi_wready,
    output logic [1:0]                                s_axi_bresp,
    output logic                                      s_axi_bvalid,
    input  wire logic                                 s_axi_bready,
    input  wire logic [halfband_pkg::AXI_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                                 s_axi_arvalid,
    output logic                                      s_axi_arready,
    output logic [31:0]                               s_axi_rdata,
    output logic [1:0]                                s_axi_rresp,
    output logic                                      s_axi_rvalid,
    input  wire logic                                 s_axi_rready
);

    localparam int ACC_W = halfband_pkg::ACC_W;
    localparam int OUT_W = halfband_pkg::OUT_W;

    sample_if sif ();

    logic [3:0]                   bits;
    logic                         ext_valid;
    logic [1:0]                   extended_mode_bits;
    logic                         extended_ctrl_enable;
    logic                         input_signed_select;
    halfband_pkg::mode_t          mode;
    logic                         sync_eff;
    logic                         soft_sync_q;
    logic [1:0]                   phase_q;
    logic                         load_phase;
    logic                         accept;
    logic                         out_load;
    logic signed [11:0]           x_q;
    logic signed [ACC_W-1:0]      pad_q [halfband_pkg::PAD_STG];
    logic signed [ACC_W-1:0]      s0_q;
    logic signed [ACC_W-1:0]      s1_q;
    logic signed [ACC_W-1:0]      xs_d;
    logic signed [ACC_W-1:0]      xs_q;
    logic signed [ACC_W-1:0]      rnd_sum;
    logic signed [ACC_W-1:0]      scaled;
    logic signed [ACC_W-1:0]      lim_hi;
    logic signed [ACC_W-1:0]      lim_lo;
    logic [OUT_W-1:0]             rnd_d;
    logic [OUT_W-1:0]             rnd_q;
    logic                         clip;
    logic [OUT_W-1:0]             dbl_q [halfband_pkg::DBL_STG];
    logic [OUT_W-1:0]             out_src;
    logic [OUT_W-1:0]             out_q;
    logic [4:0]                   shift_amt;
    logic [3:0]                   drop;
    logic                         sat_flag_q;
    logic                         aw_hold_q;
    logic                         w_hold_q;
    logic [halfband_pkg::AXI_ADDR_W-1:0] awaddr_q;
    logic [31:0]                  wdata_q;
    logic                         wstrb0_q;
    logic                         do_write;
    logic                         ctrl_write;
    logic                         bvalid_q;
    logic [1:0]                   bresp_q;
    logic                         rvalid_q;
    logic [31:0]                  rdata_q;
    logic [1:0]                   rresp_q;
    logic [31:0]                  status_word;

    // Mode pins and supplementary control lines
    assign bits                 = halfband_pkg::out_bits(round_position);
    assign extended_ctrl_enable = round_position[2];
    assign ext_valid            = extended_ctrl_enable && (bits != halfband_pkg::FULL_BITS)
                                && (bits <= halfband_pkg::EXT_BITS);
    assign extended_mode_bits   = ext_valid ? result_low_dual_bits_in[3:2] : 2'h0;
    assign input_signed_select  = (bits == halfband_pkg::FULL_BITS) ? 1'h1
                                : result_low_dual_bits_in[0];
    assign mode = halfband_pkg::decode_mode(interp_select_n, decim_select,
                                            ext_valid, extended_mode_bits);

    // Phase tracking for zero stuffing and output hold
    assign sync_eff   = sync | soft_sync_q;
    assign load_phase = mode.two_chan ? phase_q[1] : phase_q[0];
    assign accept     = !mode.interp || (!sync_eff && !load_phase);
    assign out_load   = !mode.decim || (!sync_eff && load_phase);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            phase_q <= 2'h0;
        else if (sync_eff)
            phase_q <= 2'h0;
        else
            phase_q <= phase_q + 2'h1;
    end

    // Input register with zero insertion
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            x_q <= '0;
        else if (accept)
            x_q <= {sample_in[11] ^ ~input_signed_select, sample_in[10:0]};
        else
            x_q <= '0;
    end

    assign sif.x        = x_q;
    assign sif.two_chan = mode.two_chan;
    assign sif.bypass   = mode.bypass;

    halfband_core u_core (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .sif     (sif.core)
    );

    // Alignment pipeline to the first-response latency
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < halfband_pkg::PAD_STG; i++)
                pad_q[i] <= '0;
        end
        else
        begin
            pad_q[0] <= sif.acc;
            for (int i = 1; i < halfband_pkg::PAD_STG; i++)
                pad_q[i] <= pad_q[i-1];
        end
    end

    // Three-tap sinc compensation, centre tap path when disabled
    always_comb
    begin
        xs_d = s0_q;
        if (mode.xsinx)
            xs_d = s0_q + (((s0_q <<< 1) - pad_q[halfband_pkg::PAD_STG-1] - s1_q)
                           >>> halfband_pkg::XS_SHIFT);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s0_q <= '0;
            s1_q <= '0;
            xs_q <= '0;
        end
        else
        begin
            s0_q <= pad_q[halfband_pkg::PAD_STG-1];
            s1_q <= s0_q;
            xs_q <= xs_d;
        end
    end

    // Rounding and limiting
    always_comb
    begin
        shift_amt = 5'(halfband_pkg::OUT_SHIFT) - {4'h0, mode.gain0};
        drop      = halfband_pkg::FULL_BITS - bits;
        rnd_sum   = xs_q + (ACC_W'(1) <<< (shift_amt + {1'h0, drop} - 5'h1));
        scaled    = rnd_sum >>> shift_amt;
        lim_hi    = mode.lim15 ? ACC_W'(16'sh3fff) : ACC_W'(16'sh7fff);
        lim_lo    = -lim_hi - ACC_W'(1);
        clip      = 1'h0;
        rnd_d     = scaled[OUT_W-1:0];
        if (scaled > lim_hi)
        begin
            rnd_d = lim_hi[OUT_W-1:0];
            clip  = 1'h1;
        end
        else if (scaled < lim_lo)
        begin
            rnd_d = lim_lo[OUT_W-1:0];
            clip  = 1'h1;
        end
        rnd_d = rnd_d & ~((16'h0001 << drop) - 16'h0001);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rnd_q <= '0;
        else
            rnd_q <= rnd_d;
    end

    // Double-latency delay line
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < halfband_pkg::DBL_STG; i++)
                dbl_q[i] <= '0;
        end
        else
        begin
            dbl_q[0] <= rnd_q;
            for (int i = 1; i < halfband_pkg::DBL_STG; i++)
                dbl_q[i] <= dbl_q[i-1];
        end
    end

    assign out_src = mode.dbl ? dbl_q[halfband_pkg::DBL_STG-1] : rnd_q;

    // Output register with format select
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            out_q <= '0;
        else if (out_load)
        begin
            out_q <= out_src;
            if (!output_format_select)
            begin
                if (mode.lim15)
                    out_q[14] <= ~out_src[14];
                else
                    out_q[15] <= ~out_src[15];
            end
        end
    end

    // Asynchronous bus enable, low lines float when unused
    assign result_upper_bits        = out_q[15:4];
    assign result_low_dual_bits_out = out_q[3:0];
    assign result_upper_oe          = ~out_enable_n;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_low_oe
            assign result_low_dual_bits_oe[g] = ~out_enable_n && (4'(g) >= drop);
        end
    endgenerate

    // Sticky clip flag, set wins over clear
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            sat_flag_q <= 1'h0;
        else if (clip)
            sat_flag_q <= 1'h1;
        else if (ctrl_write && wdata_q[halfband_pkg::CTRL_CLR_BIT])
            sat_flag_q <= 1'h0;
    end

    // Software phase strobe, one clock wide
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            soft_sync_q <= 1'h0;
        else
            soft_sync_q <= ctrl_write && wdata_q[halfband_pkg::CTRL_SYNC_BIT];
    end

    // AXI4-Lite write channels
    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready  = !w_hold_q && !bvalid_q;
    assign do_write      = aw_hold_q && w_hold_q && !bvalid_q;
    assign ctrl_write    = do_write && (awaddr_q == halfband_pkg::CTRL_OFF) && wstrb0_q;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_hold_q <= 1'h0;
            awaddr_q  <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_hold_q <= 1'h1;
            awaddr_q  <= s_axi_awaddr;
        end
        else if (do_write)
            aw_hold_q <= 1'h0;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w_hold_q <= 1'h0;
            wdata_q  <= '0;
            wstrb0_q <= 1'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_hold_q <= 1'h1;
            wdata_q  <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
        end
        else if (do_write)
            w_hold_q <= 1'h0;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bvalid_q <= 1'h0;
            bresp_q  <= halfband_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_q <= 1'h1;
            bresp_q  <= (awaddr_q == halfband_pkg::CTRL_OFF ||
                         awaddr_q == halfband_pkg::STATUS_OFF) ? halfband_pkg::RESP_OKAY
                                                               : halfband_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'h0;
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // AXI4-Lite read channel
    assign status_word   = {17'h0, sat_flag_q, phase_q, bits, mode};
    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rvalid_q <= 1'h0;
            rdata_q  <= '0;
            rresp_q  <= halfband_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'h1;
            case (s_axi_araddr)
                halfband_pkg::CTRL_OFF:
                begin
                    rdata_q <= '0;
                    rresp_q <= halfband_pkg::RESP_OKAY;
                end
                halfband_pkg::STATUS_OFF:
                begin
                    rdata_q <= status_word;
                    rresp_q <= halfband_pkg::RESP_OKAY;
                end
                default:
                begin
                    rdata_q <= '0;
                    rresp_q <= halfband_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            rvalid_q <= 1'h0;
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

endmodule // halfband_interp_decim_filter

/* File: dv/halfband_sample_src.sv */
// Sample source model driving data and the phase strobe
`timescale 1ns/100ps
module halfband_sample_src (
    input  wire logic        sys_clk,
    input  wire logic        align,
    input  wire logic        toggle,
    input  wire logic [11:0] data,
    output logic      [11:0] sample_in,
    output logic             sync
);
    initial
    begin
        sample_in = 12'h0;
        sync      = 1'h0;
    end
    // Strobe pulse, then low with first sample or half-rate square
    always @(posedge sys_clk)
    begin
        sample_in <= data;
        sync      <= align | (toggle & ~sync);
    end
endmodule // halfband_sample_src

/* File: dv/halfband_interp_decim_filter_sva.sv */
// Assertions on the filter top ports
`timescale 1ns/100ps
module halfband_chk (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        interp_select_n,
    input wire logic        decim_select,
    input wire logic [2:0]  round_position,
    input wire logic        out_enable_n,
    input wire logic [11:0] result_upper_bits,
    input wire logic        result_upper_oe,
    input wire logic [3:0]  result_low_dual_bits_oe,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire dec_m = interp_select_n & ~decim_select & (round_position == 3'h7);

    a_oe_async: assert property (result_upper_oe == !out_enable_n)
        else $error("upper enable wrong");
    a_low_oe_full: assert property (round_position == 3'h7 |->
        result_low_dual_bits_oe == {4{!out_enable_n}}) else $error("low enable wrong");
    a_low_oe_sign: assert property (round_position != 3'h7 |->
        !result_low_dual_bits_oe[0]) else $error("sign line driven");
    a_decim_hold: assert property (dec_m [*4] ##0 $changed(result_upper_bits) ##1 dec_m
        |-> $stable(result_upper_bits)) else $error("decimated output not held");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no write response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read response");
    a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while busy");
    a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
endmodule // halfband_chk

bind halfband_interp_decim_filter halfband_chk halfband_chk_i (
    .sys_clk, .rst_n, .interp_select_n, .decim_select, .round_position, .out_enable_n,
    .result_upper_bits, .result_upper_oe, .result_low_dual_bits_oe, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid
);

/* File: dv/halfband_interp_decim_filter_tb.sv */
// Bench: reference filter model, strobe phases, register access
`timescale 1ns/100ps
module halfband_interp_decim_filter_tb;
    logic        sys_clk, rst_n, sync, align, toggle, chk_on, result_upper_oe;
    logic        interp_select_n, decim_select, output_format_select, out_enable_n;
    logic [2:0]  round_position;
    logic [11:0] sample_in, data, result_upper_bits;
    logic [3:0]  low_drv, low_wire, result_low_dual_bits_out, result_low_dual_bits_oe;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    int          n_fail, checks_done, cyc, ph, expv, hist[$];

    assign low_wire = (result_low_dual_bits_oe & result_low_dual_bits_out)
                    | (~result_low_dual_bits_oe & low_drv);

    halfband_sample_src halfband_sample_src_i (.sys_clk, .align, .toggle, .data,
        .sample_in, .sync);

    halfband_interp_decim_filter halfband_interp_decim_filter_i (
        .sys_clk, .rst_n, .sample_in, .sync, .interp_select_n, .decim_select, .round_position,
        .output_format_select, .out_enable_n, .result_upper_bits, .result_upper_oe,
        .result_low_dual_bits_in(low_wire), .result_low_dual_bits_out, .result_low_dual_bits_oe,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    task automatic give_verdict;
        if (n_fail == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic int coef(input int d);
        int m;
        m = d < 0 ? -d : d;
        if (m == 0)
            return halfband_pkg::HB_CENTER;
        return (m % 2) ? halfband_pkg::HB_COEF[(m - 1) / 2] : 0;
    endfunction

    // One register access, write or read
    task automatic axi(input logic wr, input logic [3:0] a);
        logic aw, w, ar, done;
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_araddr  <= a;
        s_axi_awvalid <= wr;
        s_axi_wvalid  <= wr;
        s_axi_bready  <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready  <= !wr;
        done = 1'h0;
        while (!done)
        begin
            @(negedge sys_clk);
            {aw, w, ar} = {s_axi_awready, s_axi_wready, s_axi_arready};
            done = wr ? s_axi_bvalid : s_axi_rvalid;
            rs = wr ? s_axi_bresp : s_axi_rresp;
            rd = s_axi_rdata;
            @(posedge sys_clk);
            if (aw)
                s_axi_awvalid <= 1'h0;
            if (w)
                s_axi_wvalid <= 1'h0;
            if (ar)
                s_axi_arvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
    endtask

    // One stream phase: mode, strobe alignment, random samples
    task automatic run(input logic i_n, d, s, f, tg, c, input int n);
        @(posedge sys_clk);
        chk_on               <= 1'h0;
        interp_select_n      <= i_n;
        decim_select         <= d;
        low_drv              <= {3'h0, s};
        output_format_select <= f;
        toggle               <= tg;
        align                <= 1'h1;
        for (int k = 0; k < n; k++)
        begin
            @(posedge sys_clk);
            align        <= 1'h0;
            data         <= 12'($urandom_range(2047)) + (s ? 12'hc00 : 12'h400);
            out_enable_n <= !c && k % 8 == 3;
            chk_on       <= c && k >= 60;
        end
    endtask

    // Reference model of the filter at 12-bit resolution
    always @(posedge sys_clk)
    begin
        int xs, a, acc, sh, lim;
        xs = int'($signed(sample_in ^ {~low_wire[0], 11'h0}));
        a  = interp_select_n ? 1 : (sync ? 0 : ph);
        ph = (interp_select_n | sync) ? 1 : 1 - ph;
        hist.push_front(a ? xs : 0);
        acc = 0;
        for (int k = 15; k < hist.size() && k <= 53; k++)
            acc += hist[k] * coef(k - 34);
        sh   = (!interp_select_n && !decim_select) ? 14 : 15;
        lim  = (!interp_select_n && decim_select) ? 1023 : 2047;
        expv = (acc + (1 << (sh - 1))) >>> sh;
        expv = expv > lim ? lim : (expv < -lim - 1 ? -lim - 1 : expv);
        expv = expv ^ (output_format_select ? 0 : 'h800);
        if (hist.size() > 60)
            void'(hist.pop_back());
    end

    always @(negedge sys_clk)
        if (chk_on)
            cmp(32'(result_upper_bits), 32'(expv[11:0]));

    initial
    begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    initial
    begin
        void'($urandom(32'h0923));
        {rst_n, align, toggle, chk_on, out_enable_n} = 5'h0;
        {interp_select_n, decim_select, output_format_select} = 3'h7;
        {round_position, low_drv, data} = {3'h4, 4'h1, 12'h0};
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = {8'h0, 4'hf, 32'h2};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        n_fail = 0;
        checks_done = 0;
        cyc = 0;
        ph = 0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'h1;
        axi(1'h1, 4'h8);
        cmp(32'(rs), 32'(halfband_pkg::RESP_SLVERR));
        axi(1'h1, halfband_pkg::CTRL_OFF);
        cmp(32'(rs), 32'(halfband_pkg::RESP_OKAY));
        axi(1'h0, 4'hc);
        cmp({rd[29:0], rs}, 32'(halfband_pkg::RESP_SLVERR));
        axi(1'h0, halfband_pkg::STATUS_OFF);
        cmp(32'(rd[11:8]), 32'hc);
        run(1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 150);
        run(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 150);
        run(1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 200);
        run(1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 200);
        run(1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 200);
        @(posedge sys_clk);
        round_position <= 3'h7;
        run(1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 200);
        for (int r = 0; r < 8; r++)
        begin
            @(posedge sys_clk);
            round_position <= 3'(r);
        end
        @(posedge sys_clk);
        give_verdict();
    end
endmodule // halfband_interp_decim_filter_tb
